// ==== src/pmhs_cap_regs.sv ====
`timescale 1ns/10ps
module pmhs_cap_regs (
    input wire logic i_clk,              // primary bus clock
    input wire logic i_rst_b,            // primary reset, active low
    input wire logic i_cfg_rd,           // config read strobe
    input wire logic i_cfg_wr,           // config write strobe
    input wire logic [7:0] i_cfg_addr,   // dword byte address
    input wire logic [3:0] i_cfg_be_b,   // byte enables, active low
    input wire logic [31:0] i_cfg_wdata, // write data
    input wire logic i_handle_closed,    // ejector handle closed
    output logic [31:0] o_cfg_rdata,     // read data
    output logic o_cfg_rvalid,           // read data valid pulse
    output logic o_enum_o,               // enum line level, always low
    output logic o_enum_oe,              // enum line driven (asserted)
    output logic o_lamp,                 // indicator lamp on
    output logic o_chip_reset            // internal reset pulse
);

    typedef struct packed {
        logic [1:0] pstate;
        logic hide_arm;
        logic enum_irq_mask;
        logic indicator_lamp_on;
        logic removal_pending_flag;
        logic board_added_flag;
        logic [31:0] rdata;
        logic rvalid;
        logic enum_oe;
        logic enum_o;
        logic chip_reset;
    } pmhs_regs_s;

    pmhs_regs_s r_reg;
    pmhs_regs_s r_next;

    logic set_added;
    logic set_removal;
    logic hide_set;

    function automatic logic lane_wr(input logic [7:0] ofs,
                                     input int lane);
        lane_wr = i_cfg_wr && (i_cfg_addr == ofs) && !i_cfg_be_b[lane];
    endfunction : lane_wr

    function automatic logic [31:0] read_word(input pmhs_regs_s s,
                                              input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            pmhs_pkg::PM_CAP_OFS: begin
                // clock-need, aux, init, D1, D2, wake mask zero
                w[pmhs_pkg::PM_REV_LSB +: 3] = pmhs_pkg::PM_REV_VAL;
            end
            pmhs_pkg::PM_CSR_OFS: begin
                // wake, data, bridge extension bits zero
                w[pmhs_pkg::PSTATE_LSB +: 2] = s.pstate;
            end
            pmhs_pkg::HS_CAP_OFS: begin
                w[pmhs_pkg::HS_ID_LSB +: 8] = pmhs_pkg::HS_ID_VAL;
                w[pmhs_pkg::HS_NEXT_LSB +: 8] = pmhs_pkg::HS_NEXT_VAL;
                w[pmhs_pkg::HIDE_BIT] = s.hide_arm;
                w[pmhs_pkg::MASK_BIT] = s.enum_irq_mask;
                w[pmhs_pkg::LAMP_BIT] = s.indicator_lamp_on;
                w[pmhs_pkg::REMOVAL_BIT] = s.removal_pending_flag;
                w[pmhs_pkg::ADDED_BIT] = s.board_added_flag;
                // pending event and programming interface zero
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        read_word = w;
    endfunction : read_word

    pmhs_swap_fsm u_swap (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_soft_rst(r_reg.chip_reset),
        .i_handle_closed(i_handle_closed),
        .i_added_flag(r_reg.board_added_flag),
        .o_set_added(set_added),
        .o_set_removal(set_removal),
        .o_hide_set(hide_set)
    );

    logic pm_wr;
    logic hs_wr;
    logic [1:0] ps_wdata;

    assign pm_wr = lane_wr(pmhs_pkg::PM_CSR_OFS, pmhs_pkg::PSTATE_LANE);
    assign hs_wr = lane_wr(pmhs_pkg::HS_CAP_OFS, pmhs_pkg::HS_CSR_LANE);
    assign ps_wdata = i_cfg_wdata[pmhs_pkg::PSTATE_LSB +: 2];

    always_comb begin
        r_next = r_reg;
        r_next.chip_reset = 1'b0;

        if (pm_wr) begin
            // unimplemented states complete but change nothing
            if (ps_wdata == pmhs_pkg::PS_D0 ||
                ps_wdata == pmhs_pkg::PS_D3) begin
                r_next.pstate = ps_wdata;
            end
        end

        if (hs_wr) begin
            if (i_cfg_wdata[pmhs_pkg::HIDE_BIT]) begin
                r_next.hide_arm = 1'b1;
            end
            r_next.enum_irq_mask = i_cfg_wdata[pmhs_pkg::MASK_BIT];
            r_next.indicator_lamp_on =
                i_cfg_wdata[pmhs_pkg::LAMP_BIT];
            if (i_cfg_wdata[pmhs_pkg::REMOVAL_BIT]) begin
                r_next.removal_pending_flag = 1'b0;
            end
            if (i_cfg_wdata[pmhs_pkg::ADDED_BIT]) begin
                r_next.board_added_flag = 1'b0;
            end
        end

        // hardware events come after the writes so a set beats a same-cycle clear
        if (hide_set) begin
            r_next.hide_arm = 1'b1;
        end
        if (set_added) begin
            r_next.board_added_flag = 1'b1;
            r_next.hide_arm = 1'b0;
        end
        if (set_removal) begin
            r_next.removal_pending_flag = 1'b1;
        end

        // whole block back to reset; chip_reset pulses for one cycle and also resets the swap machine
        if (pm_wr && r_reg.pstate == pmhs_pkg::PS_D3 &&
            ps_wdata == pmhs_pkg::PS_D0) begin
            r_next = '0;
            r_next.pstate = pmhs_pkg::PSTATE_RST;
            r_next.chip_reset = 1'b1;
        end

        // after the soft reset so a same-cycle read still gets its answer
        r_next.rvalid = i_cfg_rd;
        r_next.rdata = i_cfg_rd ? read_word(r_reg, i_cfg_addr) :
                       pmhs_pkg::RDATA_RST;

        r_next.enum_o = 1'b0;
        r_next.enum_oe = (r_next.board_added_flag ||
                          r_next.removal_pending_flag) &&
                         !r_next.enum_irq_mask;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_cfg_rdata = r_reg.rdata;
    assign o_cfg_rvalid = r_reg.rvalid;
    assign o_enum_o = r_reg.enum_o;
    assign o_enum_oe = r_reg.enum_oe;
    assign o_lamp = r_reg.indicator_lamp_on;
    assign o_chip_reset = r_reg.chip_reset;

    // checks on the register behaviour

    pstate_legal_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        r_reg.pstate == pmhs_pkg::PS_D0 || r_reg.pstate == pmhs_pkg::PS_D3)
        else $error("power state holds an unimplemented code");

    d1d2_ignored_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        pm_wr && (ps_wdata == pmhs_pkg::PS_D1 ||
                  ps_wdata == pmhs_pkg::PS_D2) && !r_reg.chip_reset
        |=> $stable(r_reg.pstate))
        else $error("D1 or D2 write changed the power state");

    d3_d0_reset_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        pm_wr && r_reg.pstate == pmhs_pkg::PS_D3 &&
        ps_wdata == pmhs_pkg::PS_D0
        |=> o_chip_reset && !r_reg.hide_arm && !r_reg.enum_irq_mask
            ##1 !o_chip_reset)
        else $error("D3 to D0 write did not reset the block");

    pm_caps_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        i_cfg_rd && i_cfg_addr == pmhs_pkg::PM_CAP_OFS
        |=> o_cfg_rvalid && o_cfg_rdata == 32'h0002_0000)
        else $error("capability word reads wrong");

    pm_csr_zero_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        i_cfg_rd && i_cfg_addr == pmhs_pkg::PM_CSR_OFS
        |=> o_cfg_rdata[31:2] == 30'h0)
        else $error("power control word has nonzero fixed bits");

    hs_word_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        i_cfg_rd && i_cfg_addr == pmhs_pkg::HS_CAP_OFS
        |=> o_cfg_rdata[15:0] == 16'h0006 && o_cfg_rdata[18] == 1'b0 &&
            o_cfg_rdata[21:20] == 2'h0 && o_cfg_rdata[31:24] == 8'h0)
        else $error("hot-swap word fixed fields read wrong");

    hide_write_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        hs_wr && i_cfg_wdata[pmhs_pkg::HIDE_BIT] && !set_added && !pm_wr
        |=> r_reg.hide_arm)
        else $error("writing one did not arm hiding");

    hide_auto_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        (hide_set && !set_added && !pm_wr |=> r_reg.hide_arm) and
        (set_added && !pm_wr |=> !r_reg.hide_arm))
        else $error("hiding arm did not follow the swap machine");

    enum_mask_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        r_reg.enum_irq_mask |-> !o_enum_oe && !o_enum_o)
        else $error("enum driven while masked");

    enum_drive_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        o_enum_oe == ((r_reg.board_added_flag ||
                       r_reg.removal_pending_flag) && !r_reg.enum_irq_mask))
        else $error("enum drive does not match the flags");

    lamp_write_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        hs_wr && !pm_wr
        |=> o_lamp == $past(i_cfg_wdata[pmhs_pkg::LAMP_BIT]))
        else $error("lamp does not follow the written bit");

    flag_clear_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        hs_wr && i_cfg_wdata[pmhs_pkg::ADDED_BIT] && !set_added
        |=> !r_reg.board_added_flag)
        else $error("write one did not clear insertion flag");

    flag_set_wins_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        (set_added && !pm_wr |=> r_reg.board_added_flag) and
        (set_removal && !pm_wr |=> r_reg.removal_pending_flag))
        else $error("hardware flag set was lost");

    hide_keep_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        hs_wr && !i_cfg_wdata[pmhs_pkg::HIDE_BIT] && r_reg.hide_arm &&
        !set_added
        |=> r_reg.hide_arm)
        else $error("writing zero disarmed hiding");

    mask_write_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        hs_wr
        |=> r_reg.enum_irq_mask == $past(i_cfg_wdata[pmhs_pkg::MASK_BIT]))
        else $error("mask does not follow the written bit");

    state_d3_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        pm_wr && ps_wdata == pmhs_pkg::PS_D3
        |=> r_reg.pstate == pmhs_pkg::PS_D3)
        else $error("D3 write was not taken");

    state_d0_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        pm_wr && ps_wdata == pmhs_pkg::PS_D0
        |=> r_reg.pstate == pmhs_pkg::PS_D0)
        else $error("D0 write was not taken");

    pstate_read_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        i_cfg_rd && i_cfg_addr == pmhs_pkg::PM_CSR_OFS
        |=> o_cfg_rvalid && o_cfg_rdata[1:0] == $past(r_reg.pstate))
        else $error("power state read back wrong");

    removal_clear_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        hs_wr && i_cfg_wdata[pmhs_pkg::REMOVAL_BIT] && !set_removal
        |=> !r_reg.removal_pending_flag)
        else $error("write one did not clear removal flag");

    flag_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        (hs_wr && !i_cfg_wdata[pmhs_pkg::ADDED_BIT] &&
         r_reg.board_added_flag |=> r_reg.board_added_flag) and
        (hs_wr && !i_cfg_wdata[pmhs_pkg::REMOVAL_BIT] &&
         r_reg.removal_pending_flag |=> r_reg.removal_pending_flag))
        else $error("write zero cleared a flag");

    reset_pulse_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        o_chip_reset |=> !o_chip_reset)
        else $error("internal reset lasted more than one cycle");

    lamp_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        !hs_wr && !pm_wr |=> $stable(o_lamp))
        else $error("lamp moved without a write");

    removal_enum_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        r_reg.removal_pending_flag && !r_reg.enum_irq_mask |-> o_enum_oe)
        else $error("removal flag set but enum not driven");

endmodule : pmhs_cap_regs

// ==== src/pmhs_pkg.sv ====
// Overview of operation
// - power state field, 00 D0, 11 D3
// - D1/D2 writes accepted, field left unchanged
// - D3 to D0 write resets whole device
// - pm revision reports version 1.1
// - wake and aux capability fields read zero
// - wake enable/status, data select/scale read zero
// - bridge extension bits read zero
// - hot-swap capability id reads 0x6
// - writing 1 arms device hiding
// - hiding armed at reset release, handle open
// - hiding disarmed on entering insertion state
// - mask bit set keeps enum line undriven
// - lamp bit drives external indicator
// - pending event and prog interface read zero
// - removal flag set, enum driven while set and unmasked
// - insertion flag after handle closed, reset released
package pmhs_pkg;

    // config dword byte addresses
    localparam logic [7:0] PM_CAP_OFS = 8'h80;
    localparam logic [7:0] PM_CSR_OFS = 8'h84;
    localparam logic [7:0] HS_CAP_OFS = 8'h90;

    // field positions
    localparam int PM_REV_LSB = 16;
    localparam int PSTATE_LSB = 0;
    localparam int HS_ID_LSB = 0;
    localparam int HS_NEXT_LSB = 8;
    localparam int HIDE_BIT = 16;
    localparam int MASK_BIT = 17;
    localparam int LAMP_BIT = 19;
    localparam int REMOVAL_BIT = 22;
    localparam int ADDED_BIT = 23;

    // byte lanes that carry writable fields
    localparam int PSTATE_LANE = 0;
    localparam int HS_CSR_LANE = 2;

    // constant field values
    localparam logic [2:0] PM_REV_VAL = 3'h2;
    localparam logic [7:0] HS_ID_VAL = 8'h06;
    localparam logic [7:0] HS_NEXT_VAL = 8'h00;

    // power state codes
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D1 = 2'h1;
    localparam logic [1:0] PS_D2 = 2'h2;
    localparam logic [1:0] PS_D3 = 2'h3;

    // reset values
    localparam logic [1:0] PSTATE_RST = 2'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    typedef enum logic [3:0] {
        PMHS_ST_START = 4'h1,
        PMHS_ST_ADDED = 4'h2,
        PMHS_ST_RUN = 4'h4,
        PMHS_ST_REMOVAL = 4'h8
    } pmhs_swap_e;

endpackage : pmhs_pkg

// ==== src/pmhs_swap_fsm.sv ====
`timescale 1ns/10ps
module pmhs_swap_fsm (
    input wire logic i_clk,            // primary bus clock
    input wire logic i_rst_b,          // primary reset, active low
    input wire logic i_soft_rst,       // internal reset pulse
    input wire logic i_handle_closed,  // ejector handle closed level
    input wire logic i_added_flag,     // insertion flag as stored
    output logic o_set_added,          // pulse: set insertion flag
    output logic o_set_removal,        // pulse: set removal flag
    output logic o_hide_set            // pulse: arm device hiding
);

    typedef struct packed {
        pmhs_pkg::pmhs_swap_e st;
        logic hide_done;
        logic set_added;
        logic set_removal;
        logic hide_set;
    } pmhs_fsm_s;

    pmhs_fsm_s r_reg;
    pmhs_fsm_s r_next;

    always_comb begin
        r_next = r_reg;
        r_next.set_added = 1'b0;
        r_next.set_removal = 1'b0;
        r_next.hide_set = 1'b0;
        case (r_reg.st)
            pmhs_pkg::PMHS_ST_START: begin
                if (i_handle_closed) begin
                    r_next.set_added = 1'b1;
                    r_next.st = pmhs_pkg::PMHS_ST_ADDED;
                end else if (!r_reg.hide_done) begin
                    r_next.hide_set = 1'b1;
                    r_next.hide_done = 1'b1;
                end
            end
            pmhs_pkg::PMHS_ST_ADDED: begin
                // the stored flag lags our pulse by one cycle
                if (!i_added_flag && !r_reg.set_added) begin
                    r_next.st = pmhs_pkg::PMHS_ST_RUN;
                end
            end
            pmhs_pkg::PMHS_ST_RUN: begin
                if (!i_handle_closed) begin
                    r_next.set_removal = 1'b1;
                    r_next.st = pmhs_pkg::PMHS_ST_REMOVAL;
                end
            end
            pmhs_pkg::PMHS_ST_REMOVAL: begin
                if (i_handle_closed) begin
                    r_next.set_added = 1'b1;
                    r_next.st = pmhs_pkg::PMHS_ST_ADDED;
                end
            end
            default: begin
                r_next.st = pmhs_pkg::PMHS_ST_START;
            end
        endcase
        if (i_soft_rst) begin
            r_next = '0;
            r_next.st = pmhs_pkg::PMHS_ST_START;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r_reg <= '0;
            r_reg.st <= pmhs_pkg::PMHS_ST_START;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_set_added = r_reg.set_added;
    assign o_set_removal = r_reg.set_removal;
    assign o_hide_set = r_reg.hide_set;

endmodule : pmhs_swap_fsm

// ==== verification/pmhs_board_model.sv ====
`timescale 1ns/10ps
module pmhs_board_model (
    input wire logic i_clk,       // primary bus clock
    input wire logic i_close,     // bench moves the lever: 1 closed
    output logic o_handle_closed  // ejector switch level
);
    // switch settles one clock after the lever moves; unknown only in reset
    always @(posedge i_clk) begin
        o_handle_closed <= i_close;
    end
endmodule : pmhs_board_model

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic cfg_rd = 1'b0;
    logic cfg_wr = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be_b = 4'hf;
    logic [31:0] cfg_wdata = 32'h0;
    logic close_req = 1'b1;
    logic handle_closed, rvalid, enum_o, enum_oe, lamp, chip_rst, hit;
    logic [31:0] rdata, d;
    int errors = 0;
    int cmp_count = 0;
    integer seed = 66;

    always #4 i_clk = ~i_clk;

    pmhs_board_model i_pmhs_board_model (
        .i_clk(i_clk), .i_close(close_req), .o_handle_closed(handle_closed));

    pmhs_cap_regs i_pmhs_cap_regs (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg_rd(cfg_rd),
        .i_cfg_wr(cfg_wr), .i_cfg_addr(cfg_addr), .i_cfg_be_b(cfg_be_b),
        .i_cfg_wdata(cfg_wdata), .i_handle_closed(handle_closed),
        .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .o_enum_o(enum_o),
        .o_enum_oe(enum_oe), .o_lamp(lamp), .o_chip_reset(chip_rst));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    function logic [31:0] hs_word(input logic added, input logic removal,
                                  input logic lamp_on, input logic mask,
                                  input logic hide);
        return {8'h00, added, removal, 2'h0, lamp_on, 1'b0, mask, hide,
                16'h0006};
    endfunction : hs_word

    task cfg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge i_clk);
        cfg_rd <= 1'b0;
        #1;
        check(rvalid, 1'b1);
        check(rdata, exp);
    endtask : cfg_read

    task cfg_write(input logic [7:0] a, input logic [3:0] be,
                   input logic [31:0] dw);
        @(posedge i_clk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_be_b <= be;
        cfg_wdata <= dw;
        @(posedge i_clk);
        cfg_wr <= 1'b0;
        #1;
    endtask : cfg_write

    // hot-swap control lives in lane 2 only
    task hs_write(input logic [31:0] dw);
        cfg_write(8'h90, 4'b1011, dw);
    endtask : hs_write

    task settle;
        repeat (4) @(posedge i_clk);
        #1;
    endtask : settle

    task do_reset(input logic closed);
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        close_req <= closed;
        repeat (12) @(posedge i_clk);
        i_rst_b <= 1'b1;
        settle;
    endtask : do_reset

    task final_report;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #200000;
        errors++;
        final_report;
    end

    initial begin
        do_reset(1'b1);
        check(enum_oe, 1'b1);
        check(enum_o, 1'b0);
        cfg_read(8'h90, hs_word(1, 0, 0, 0, 0));
        cfg_read(8'h80, 32'h0002_0000);
        cfg_read(8'h84, 32'h0);
        hs_write(32'h0);
        cfg_read(8'h90, hs_word(1, 0, 0, 0, 0));
        hs_write(32'h0080_0000);
        check(enum_oe, 1'b0);
        hs_write(32'h000b_0000);
        check(lamp, 1'b1);
        cfg_read(8'h90, hs_word(0, 0, 1, 1, 1));
        // lever opens while masked: flag rises, line stays quiet
        close_req <= 1'b0;
        settle;
        check(enum_oe, 1'b0);
        cfg_read(8'h90, hs_word(0, 1, 1, 1, 1));
        hs_write(32'h0008_0000);
        check(enum_oe, 1'b1);
        hs_write(32'h0048_0000);
        check(enum_oe, 1'b0);
        close_req <= 1'b1;
        settle;
        check(enum_oe, 1'b1);
        cfg_read(8'h90, hs_word(1, 0, 1, 0, 0));
        hs_write(32'h0088_0000);
        cfg_write(8'h84, 4'b1110, 32'h0000_0003);
        cfg_read(8'h84, 32'h0000_0003);
        for (int c = 1; c < 3; c++) begin
            d = $random(seed);
            cfg_write(8'h84, 4'b0000, {d[31:2], c[1:0]});
            cfg_read(8'h84, 32'h0000_0003);
        end
        cfg_write(8'h84, 4'b1110, 32'h0);
        hit = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (chip_rst === 1'b1) begin
                hit = 1'b1;
            end
            @(posedge i_clk);
            #1;
        end
        check(hit, 1'b1);
        settle;
        check(lamp, 1'b0);
        cfg_read(8'h84, 32'h0);
        // unmapped space, read-only dword and random lamp values
        for (int i = 0; i < 12; i++) begin
            d = $random(seed);
            cfg_read(d[7:0] & 8'h7c, 32'h0);
            cfg_write(8'h80, d[3:0], d);
            cfg_read(8'h80, 32'h0002_0000);
            hs_write({12'h000, d[19], 3'b010, 16'h0000});
            check(lamp, d[19]);
        end
        // second reset with the lever open arms hiding
        do_reset(1'b0);
        cfg_read(8'h90, hs_word(0, 0, 0, 0, 1));
        final_report;
    end
endmodule : testbench
